// ---- inc/prt_pkg.sv ----
// shared constants, types and decode helpers for the throttle control block
package prt_pkg;

   // privilege level of the requesting instruction
   typedef enum logic [1:0] {
      PRT_EL0 = 2'b00,
      PRT_EL1 = 2'b01,
      PRT_EL2 = 2'b10,
      PRT_EL3 = 2'b11
   } prt_el_t;

   // system register encodings packed as {op0, op1, crn, crm, op2}
   localparam logic [15:0] PRT_ENC_CTL2 = 16'hc78d;
   localparam logic [15:0] PRT_ENC_PPM = 16'hc794;

   // syndrome class reported with every system access trap
   localparam logic [5:0] PRT_EC_SYSREG = 6'h18;

   // register widths
   localparam int PRT_REG_W = 64;
   localparam int PRT_CTL2_W = 15;

   // field positions of the prefetch and request throttle control register
   localparam int PRT_PF_LSB = 11;
   localparam int PRT_PF_W = 4;
   localparam int PRT_WIN_LSB = 9;
   localparam int PRT_THR_LSB = 7;
   localparam int PRT_DEC_LSB = 5;
   localparam int PRT_INC_LSB = 3;
   localparam int PRT_DYN_BIT = 2;
   localparam int PRT_CAP_LSB = 0;

   // reset values
   localparam logic [14:0] PRT_CTL2_RST = 15'h0000;
   localparam logic [63:0] PRT_PPM_RST = 64'h0;

   // last defined prefetch range code, later codes are reserved
   localparam logic [3:0] PRT_PF_LAST = 4'h9;

   // default depth of the level2 transaction queue
   localparam int PRT_TQ_SIZE = 64;

   // busy classes: full means throttle down, below low means speed up
   localparam logic [2:0] PRT_BUSY_FULL = 3'h3;
   localparam logic [2:0] PRT_BUSY_LOW = 3'h2;

   // sample window size as a power of two
   function automatic logic [3:0] prt_win_log2(input logic [1:0] c);
      case (c)
         2'b00: prt_win_log2 = 4'h8;
         2'b01: prt_win_log2 = 4'h6;
         2'b10: prt_win_log2 = 4'h7;
         default: prt_win_log2 = 4'h9;
      endcase
   endfunction

   // valid fraction as a right shift of the window size
   function automatic logic [3:0] prt_thr_shift(input logic [1:0] c);
      case (c)
         2'b00: prt_thr_shift = 4'h4;
         2'b01: prt_thr_shift = 4'h5;
         2'b10: prt_thr_shift = 4'h3;
         default: prt_thr_shift = 4'h2;
      endcase
   endfunction

   // limit step for the up and down step fields
   function automatic logic [4:0] prt_step(input logic [1:0] c);
      case (c)
         2'b00: prt_step = 5'h04;
         2'b01: prt_step = 5'h08;
         2'b10: prt_step = 5'h10;
         default: prt_step = 5'h02;
      endcase
   endfunction

endpackage

// ---- rtl/prt_access.sv ----
// privilege check and trap routing for the system register accesses
`timescale 1ns/1ps
module prt_access (
   input wire prt_pkg::prt_el_t el_i,
   input wire logic el2_enabled_i,
   input wire logic impl_defined_access_trap_i,
   input wire logic el2_wen_i,
   input wire logic el3_wen_i,
   input wire logic write_i,
   input wire logic sel_ctl2_i,
   input wire logic sel_ppm_i,
   output logic undef_o,
   output logic trap_o,
   output logic trap_el3_o,
   output logic grant_o
);
   import prt_pkg::*;

   // first matching check wins, in the order the level checks are made
   always_comb begin
      undef_o = 1'b0;
      trap_o = 1'b0;
      trap_el3_o = 1'b0;
      grant_o = 1'b0;
      if (!(sel_ctl2_i | sel_ppm_i)) begin
         undef_o = 1'b1; // unknown encoding
      end else if (sel_ppm_i) begin
         if (el_i == PRT_EL3) begin
            grant_o = 1'b1;
         end else begin
            undef_o = 1'b1;
         end
      end else begin
         case (el_i)
            PRT_EL0: begin
               undef_o = 1'b1;
            end
            PRT_EL1: begin
               if (el2_enabled_i && impl_defined_access_trap_i) begin
                  trap_o = 1'b1;
               end else if (write_i && el2_enabled_i && !el2_wen_i) begin
                  trap_o = 1'b1;
               end else if (write_i && !el3_wen_i) begin
                  trap_o = 1'b1;
                  trap_el3_o = 1'b1;
               end else begin
                  grant_o = 1'b1;
               end
            end
            PRT_EL2: begin
               if (write_i && el2_enabled_i && !el2_wen_i) begin
                  trap_o = 1'b1;
               end else if (write_i && !el3_wen_i) begin
                  trap_o = 1'b1;
                  trap_el3_o = 1'b1;
               end else begin
                  grant_o = 1'b1;
               end
            end
            default: begin
               grant_o = 1'b1;
            end
         endcase
      end
   end

endmodule

// ---- rtl/prt_busy_sampler.sv ----
// busy sample window: counts responses per class and judges each window
`timescale 1ns/1ps
module prt_busy_sampler #(
   parameter int CW = 10
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic [1:0] win_sel_i,
   input wire logic [1:0] thr_sel_i,
   input wire logic rsp_valid_i,
   input wire logic [2:0] rsp_busy_i,
   input wire logic dat_valid_i,
   input wire logic [2:0] dat_busy_i,
   output logic done_o,
   output logic down_o,
   output logic up_o
);
   import prt_pkg::*;

   // a window of 512 plus one overshoot must fit
   if (CW < 10) begin : g_bad_cw
      $error("sampler counter too narrow");
   end

   logic [CW-1:0] win_size;
   logic [CW-1:0] thr;
   logic [CW-1:0] sum [3];
   logic close;

   // window length and valid threshold from the control fields
   assign win_size = CW'(1) << prt_win_log2(win_sel_i);
   assign thr = win_size >> prt_thr_shift(thr_sel_i);

   // class 0 counts all responses, 1 counts full busy, 2 counts low busy
   for (genvar g = 0; g < 3; g++) begin : g_cls
      logic [CW-1:0] cnt_q;
      logic hit_r;
      logic hit_d;
      if (g == 0) begin : g_all
         assign hit_r = rsp_valid_i;
         assign hit_d = dat_valid_i;
      end else if (g == 1) begin : g_full
         assign hit_r = rsp_valid_i && (rsp_busy_i == PRT_BUSY_FULL);
         assign hit_d = dat_valid_i && (dat_busy_i == PRT_BUSY_FULL);
      end else begin : g_low
         assign hit_r = rsp_valid_i && (rsp_busy_i < PRT_BUSY_LOW);
         assign hit_d = dat_valid_i && (dat_busy_i < PRT_BUSY_LOW);
      end
      assign sum[g] = cnt_q + CW'({1'b0, hit_r} + {1'b0, hit_d});
      // counters start empty and clear at each window close
      always_ff @(posedge mclk_i) begin
         if (!rst_n_i) begin
            cnt_q <= '0;
         end else if (ce_i) begin
            cnt_q <= close ? '0 : sum[g];
         end
      end
   end

   assign close = (sum[0] >= win_size);

   // verdict of the closing window, full busy has priority over low busy
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         done_o <= 1'b0;
         down_o <= 1'b0;
         up_o <= 1'b0;
      end else if (ce_i) begin
         done_o <= close;
         down_o <= close && (sum[1] >= thr);
         up_o <= close && (sum[1] < thr) && (sum[2] >= thr);
      end
   end

endmodule

// ---- rtl/prt_top.sv ----
// prefetch and request throttle control: registers, checks, limit logic
`timescale 1ns/1ps
module prt_top #(
   parameter int TQ_SIZE = prt_pkg::PRT_TQ_SIZE
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic sr_req_i,
   input wire logic sr_write_i,
   input wire logic [15:0] sr_enc_i,
   input wire prt_pkg::prt_el_t sr_el_i,
   input wire logic [63:0] sr_wdata_i,
   input wire logic el2_enabled_i,
   input wire logic impl_defined_access_trap_i,
   input wire logic el2_wen_i,
   input wire logic el3_wen_i,
   input wire logic rsp_busy_valid_i,
   input wire logic [2:0] rsp_busy_i,
   input wire logic dat_busy_valid_i,
   input wire logic [2:0] dat_busy_i,
   input wire logic txreq_issue_i,
   input wire logic txreq_done_i,
   output logic sr_resp_o,
   output logic [63:0] sr_rdata_o,
   output logic sr_undef_o,
   output logic sr_trap_o,
   output logic sr_trap_el3_o,
   output logic [5:0] sr_syndrome_o,
   output logic [1:0] pf_range_min_o,
   output logic [1:0] pf_range_max_o,
   output logic [$clog2(TQ_SIZE):0] req_limit_o,
   output logic [$clog2(TQ_SIZE):0] req_outstanding_o,
   output logic req_allow_o
);
   import prt_pkg::*;

   localparam int LW = $clog2(TQ_SIZE) + 1;
   localparam logic [LW-1:0] TQ_FULL = LW'(TQ_SIZE);
   localparam logic [LW-1:0] TQ_HALF = LW'(TQ_SIZE / 2);
   localparam logic [LW-1:0] TQ_QTR = LW'(TQ_SIZE / 4);
   localparam logic [LW-1:0] TQ_3QTR = LW'(TQ_SIZE - TQ_SIZE / 4);

   // quarter steps of the queue must be whole and non zero
   if ((TQ_SIZE < 8) || (TQ_SIZE % 4 != 0)) begin : g_bad_tq
      $error("queue size must be a multiple of four, at least eight");
   end

   logic sel_ctl2;
   logic sel_ppm;
   logic take;
   logic acc_undef;
   logic acc_trap;
   logic acc_trap_el3;
   logic acc_grant;
   logic wr_ctl2;
   logic wr_ppm;
   logic [63:0] rd_data;
   logic [14:0] ctl2_q;
   logic [63:0] ppm_q;
   logic [3:0] f_pf;
   logic [1:0] f_win;
   logic [1:0] f_thr;
   logic [1:0] f_dec;
   logic [1:0] f_inc;
   logic f_dyn;
   logic [1:0] f_cap;
   logic [1:0] pf_min;
   logic [1:0] pf_max;
   logic smp_done;
   logic smp_down;
   logic smp_up;
   logic [LW-1:0] cap;
   logic [LW:0] dn_need;
   logic [LW:0] up_sum;
   logic [LW-1:0] limit_d;
   logic [LW-1:0] limit_q;
   logic [LW-1:0] outst_d;
   logic [LW-1:0] outst_q;

   // decode of the addressed register and the accepted request
   assign sel_ctl2 = (sr_enc_i == PRT_ENC_CTL2);
   assign sel_ppm = (sr_enc_i == PRT_ENC_PPM);
   assign take = ce_i & sr_req_i;

   // privilege checks and trap routing
   prt_access u_access (
      .el_i(sr_el_i),
      .el2_enabled_i(el2_enabled_i),
      .impl_defined_access_trap_i(impl_defined_access_trap_i),
      .el2_wen_i(el2_wen_i),
      .el3_wen_i(el3_wen_i),
      .write_i(sr_write_i),
      .sel_ctl2_i(sel_ctl2),
      .sel_ppm_i(sel_ppm),
      .undef_o(acc_undef),
      .trap_o(acc_trap),
      .trap_el3_o(acc_trap_el3),
      .grant_o(acc_grant)
   );

   // a write only lands once every check has passed
   assign wr_ctl2 = take & acc_grant & sr_write_i & sel_ctl2;
   assign wr_ppm = take & acc_grant & sr_write_i & sel_ppm;

   // control register, only the defined low bits are kept
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         ctl2_q <= PRT_CTL2_RST;
      end else if (wr_ctl2) begin
         ctl2_q <= sr_wdata_i[PRT_CTL2_W-1:0];
      end
   end

   // management register holds whatever software writes, steering nothing
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         ppm_q <= PRT_PPM_RST;
      end else if (wr_ppm) begin
         ppm_q <= sr_wdata_i;
      end
   end

   // field views of the control register
   assign f_pf = ctl2_q[PRT_PF_LSB +: PRT_PF_W];
   assign f_win = ctl2_q[PRT_WIN_LSB +: 2];
   assign f_thr = ctl2_q[PRT_THR_LSB +: 2];
   assign f_dec = ctl2_q[PRT_DEC_LSB +: 2];
   assign f_inc = ctl2_q[PRT_INC_LSB +: 2];
   assign f_dyn = ctl2_q[PRT_DYN_BIT];
   assign f_cap = ctl2_q[PRT_CAP_LSB +: 2];

   // read data, reserved upper bits read as zero
   always_comb begin
      rd_data = '0;
      if (acc_grant && !sr_write_i) begin
         if (sel_ctl2) begin
            rd_data = {{(PRT_REG_W - PRT_CTL2_W){1'b0}}, ctl2_q};
         end else if (sel_ppm) begin
            rd_data = ppm_q;
         end
      end
   end

   // response one cycle after each accepted request
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         sr_resp_o <= 1'b0;
         sr_rdata_o <= '0;
         sr_undef_o <= 1'b0;
         sr_trap_o <= 1'b0;
         sr_trap_el3_o <= 1'b0;
         sr_syndrome_o <= '0;
      end else if (ce_i) begin
         sr_resp_o <= sr_req_i;
         if (sr_req_i) begin
            sr_rdata_o <= rd_data;
            sr_undef_o <= acc_undef;
            sr_trap_o <= acc_trap;
            sr_trap_el3_o <= acc_trap_el3;
            sr_syndrome_o <= acc_trap ? PRT_EC_SYSREG : 6'h00;
         end
      end
   end

   // allowed prefetch mode range, each code names its lowest and highest
   always_comb begin
      pf_min = 2'h0;
      pf_max = 2'h3;
      case (f_pf)
         4'h0: {pf_min, pf_max} = 4'h0;
         4'h1: {pf_min, pf_max} = 4'h1;
         4'h2: {pf_min, pf_max} = 4'h2;
         4'h3: {pf_min, pf_max} = 4'h3;
         4'h4: {pf_min, pf_max} = 4'h5;
         4'h5: {pf_min, pf_max} = 4'h6;
         4'h6: {pf_min, pf_max} = 4'h7;
         4'h7: {pf_min, pf_max} = 4'ha;
         4'h8: {pf_min, pf_max} = 4'hb;
         PRT_PF_LAST: {pf_min, pf_max} = 4'hf;
         default: {pf_min, pf_max} = 4'h3;
      endcase
   end

   // registered prefetch range for the prefetcher
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         pf_range_min_o <= 2'h0;
         pf_range_max_o <= 2'h0;
      end else if (ce_i) begin
         pf_range_min_o <= pf_min;
         pf_range_max_o <= pf_max;
      end
   end

   // busy sampling over response and data receive channels
   prt_busy_sampler #(
      .CW(10)
   ) u_sampler (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .win_sel_i(f_win),
      .thr_sel_i(f_thr),
      .rsp_valid_i(rsp_busy_valid_i),
      .rsp_busy_i(rsp_busy_i),
      .dat_valid_i(dat_busy_valid_i),
      .dat_busy_i(dat_busy_i),
      .done_o(smp_done),
      .down_o(smp_down),
      .up_o(smp_up)
   );

   // static cap as a share of the transaction queue
   always_comb begin
      case (f_cap)
         2'b00: cap = TQ_FULL;
         2'b01: cap = TQ_3QTR;
         2'b10: cap = TQ_HALF;
         default: cap = TQ_QTR;
      endcase
   end

   // step arithmetic one bit wider so nothing wraps
   assign dn_need = {1'b0, TQ_QTR} + (LW + 1)'(prt_step(f_dec));
   assign up_sum = {1'b0, limit_q} + (LW + 1)'(prt_step(f_inc));

   // next limit: static, or adapted between the quarter floor and the cap
   always_comb begin
      limit_d = limit_q;
      if (!f_dyn) begin
         limit_d = cap;
      end else if (limit_q > cap) begin
         limit_d = cap;
      end else if (smp_done && smp_down) begin
         if ({1'b0, limit_q} >= dn_need) begin
            limit_d = limit_q - LW'(prt_step(f_dec));
         end else begin
            limit_d = TQ_QTR;
         end
      end else if (smp_done && smp_up) begin
         if (up_sum >= {1'b0, cap}) begin
            limit_d = cap;
         end else begin
            limit_d = up_sum[LW-1:0];
         end
      end
   end

   // limit register starts at the default static cap
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         limit_q <= TQ_FULL;
      end else if (ce_i) begin
         limit_q <= limit_d;
      end
   end

   // outstanding request count, saturating at both ends
   always_comb begin
      outst_d = outst_q;
      if (txreq_issue_i && !txreq_done_i && (outst_q != TQ_FULL)) begin
         outst_d = outst_q + LW'(1);
      end else if (!txreq_issue_i && txreq_done_i && (outst_q != '0)) begin
         outst_d = outst_q - LW'(1);
      end
   end

   // count and issue permission against the active limit
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         outst_q <= '0;
         req_allow_o <= 1'b0;
      end else if (ce_i) begin
         outst_q <= outst_d;
         req_allow_o <= (outst_d < limit_d);
      end
   end

   assign req_limit_o = limit_q;
   assign req_outstanding_o = outst_q;

endmodule

// ---- test/prt_props.sv ----
// checker for access routing, read data and limit bounds of prt_top
`timescale 1ns/1ps
module prt_props #(
   parameter int TQ_SIZE = prt_pkg::PRT_TQ_SIZE
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic sr_req_i,
   input wire logic sr_write_i,
   input wire logic [15:0] sr_enc_i,
   input wire prt_pkg::prt_el_t sr_el_i,
   input wire logic el2_enabled_i,
   input wire logic impl_defined_access_trap_i,
   input wire logic el2_wen_i,
   input wire logic el3_wen_i,
   input wire logic sr_resp_o,
   input wire logic [63:0] sr_rdata_o,
   input wire logic sr_undef_o,
   input wire logic sr_trap_o,
   input wire logic sr_trap_el3_o,
   input wire logic [5:0] sr_syndrome_o,
   input wire logic [$clog2(TQ_SIZE):0] req_limit_o,
   input wire logic [$clog2(TQ_SIZE):0] req_outstanding_o,
   input wire logic req_allow_o
);
   import prt_pkg::*;
   logic tk;
   logic ctl;
   logic itr;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   // a request taken this edge, and whether it names the control register
   assign tk = sr_req_i && ce_i;
   assign ctl = sr_enc_i == PRT_ENC_CTL2;
   assign itr = el2_enabled_i && impl_defined_access_trap_i;
   rd_grant_a: assert property (tk && ctl && !sr_write_i &&
      sr_el_i != PRT_EL0 && !(sr_el_i == PRT_EL1 && itr)
      |=> sr_resp_o && !sr_undef_o && !sr_trap_o && !sr_trap_el3_o)
      else $error("untrapped read was refused");
   el0_undef_a: assert property (tk && sr_el_i == PRT_EL0
      |=> sr_undef_o && !sr_trap_o) else $error("level 0 access not undefined");
   impl_trap_a: assert property (tk && ctl && sr_el_i == PRT_EL1 &&
      itr |=> sr_trap_o && !sr_trap_el3_o &&
      sr_syndrome_o == PRT_EC_SYSREG) else $error("kernel access not trapped");
   hyp_wen_a: assert property (tk && ctl && sr_write_i &&
      (sr_el_i == PRT_EL1 || sr_el_i == PRT_EL2) && !itr &&
      el2_enabled_i && !el2_wen_i |=> sr_trap_o && !sr_trap_el3_o)
      else $error("write not trapped to hypervisor");
   mon_wen_a: assert property (tk && ctl && sr_write_i &&
      sr_el_i == PRT_EL2 && (!el2_enabled_i || el2_wen_i) && !el3_wen_i
      |=> sr_trap_el3_o && sr_syndrome_o == PRT_EC_SYSREG)
      else $error("write not trapped to monitor");
   mon_write_a: assert property (tk && ctl && sr_write_i &&
      sr_el_i == PRT_EL3 |=> !sr_undef_o && !sr_trap_o && !sr_trap_el3_o)
      else $error("monitor write refused");
   ppm_undef_a: assert property (tk && sr_enc_i == PRT_ENC_PPM &&
      sr_el_i != PRT_EL3 |=> sr_undef_o && sr_rdata_o == 64'h0)
      else $error("low level management access not undefined");
   rsvd_zero_a: assert property (sr_resp_o &&
      $past(sr_enc_i) == PRT_ENC_CTL2 |-> sr_rdata_o[63:15] == 49'h0)
      else $error("reserved control bits read nonzero");
   limit_range_a: assert property (req_limit_o >= TQ_SIZE / 4 &&
      req_limit_o <= TQ_SIZE) else $error("limit out of range");
   allow_cap_a: assert property (req_allow_o
      |-> req_outstanding_o < req_limit_o) else $error("allow above cap");
   cover property (tk && sr_el_i == PRT_EL1 && itr);
   cover property (req_limit_o < $past(req_limit_o));
   cover property (req_outstanding_o != 0 && !req_allow_o);
endmodule
bind prt_top prt_props #(.TQ_SIZE(TQ_SIZE)) props_u (.mclk_i, .rst_n_i,
   .ce_i, .sr_req_i, .sr_write_i, .sr_enc_i, .sr_el_i, .el2_enabled_i,
   .impl_defined_access_trap_i, .el2_wen_i, .el3_wen_i, .sr_resp_o,
   .sr_rdata_o, .sr_undef_o, .sr_trap_o, .sr_trap_el3_o, .sr_syndrome_o,
   .req_limit_o, .req_outstanding_o, .req_allow_o);

// ---- test/prt_busy_partner.sv ----
// interconnect model returning busy values on response and data channels
`timescale 1ns/1ps
module prt_busy_partner (
   input wire logic mclk_i,
   output logic rsp_busy_valid_o,
   output logic [2:0] rsp_busy_o,
   output logic dat_busy_valid_o,
   output logic [2:0] dat_busy_o
);
   logic act;
   // quiet start
   initial begin
      act = 1'b0;
      rsp_busy_valid_o = 1'b0;
      dat_busy_valid_o = 1'b0;
      rsp_busy_o = 3'h0;
      dat_busy_o = 3'h0;
   end
   // idle busy lines wander so a stale value never looks like data
   always @(posedge mclk_i) begin
      if (!act) begin
         rsp_busy_o <= rsp_busy_o + 3'h1;
         dat_busy_o <= dat_busy_o - 3'h3;
      end
   end
   // n responses alternating over both channels, the first k carry hot
   task automatic burst(input int n, input int k, input logic [2:0] hot,
      input logic [2:0] cold);
      logic [2:0] v;
      act = 1'b1;
      for (int i = 0; i < n; i++) begin
         @(posedge mclk_i);
         v = (i < k) ? hot : cold;
         rsp_busy_valid_o <= ~i[0];
         dat_busy_valid_o <= i[0];
         rsp_busy_o <= i[0] ? ~rsp_busy_o : v;
         dat_busy_o <= i[0] ? v : ~dat_busy_o;
      end
      @(posedge mclk_i);
      rsp_busy_valid_o <= 1'b0;
      dat_busy_valid_o <= 1'b0;
      act = 1'b0;
   endtask
endmodule

// ---- test/tb.sv ----
// bench for the throttle control block: access, fields, limit, count
`timescale 1ns/1ps
module tb;
   import prt_pkg::*;
   localparam int TQ = 16;
   localparam int LW = $clog2(TQ) + 1;
   logic mclk_i, rst_n_i, ce_i, sr_req_i, sr_write_i, el2_enabled_i;
   logic itrap, el2_wen_i, el3_wen_i, txreq_issue_i, txreq_done_i;
   logic rsp_busy_valid_i, dat_busy_valid_i, sr_resp_o, sr_undef_o;
   logic sr_trap_o, sr_trap_el3_o, req_allow_o;
   logic [15:0] sr_enc_i;
   prt_el_t sr_el_i;
   logic [63:0] sr_wdata_i, sr_rdata_o;
   logic [2:0] rsp_busy_i, dat_busy_i, f;
   logic [5:0] sr_syndrome_o;
   logic [1:0] pf_range_min_o, pf_range_max_o;
   logic [LW-1:0] req_limit_o, req_outstanding_o;
   logic [14:0] shadow;
   int err_count = 0;
   int comparisons = 0;
   logic [3:0] pft [0:10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7,
      4'ha, 4'hb, 4'hf, 4'h3};
   // bursts: hot count, hot value, other value, expected limit
   int bk [0:6] = '{15, 16, 16, 16, 16, 16, 0};
   logic [2:0] bh [0:6] = '{3'h3, 3'h3, 3'h3, 3'h0, 3'h1, 3'h3, 3'h2};
   logic [2:0] bc [0:6] = '{3'h2, 3'h0, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2};
   int bl [0:6] = '{16, 8, 4, 6, 8, 8, 4};

   prt_top #(.TQ_SIZE(TQ)) dut_u (.mclk_i, .rst_n_i, .ce_i, .sr_req_i,
      .sr_write_i, .sr_enc_i, .sr_el_i, .sr_wdata_i, .el2_enabled_i,
      .impl_defined_access_trap_i(itrap), .el2_wen_i, .el3_wen_i,
      .rsp_busy_valid_i, .rsp_busy_i, .dat_busy_valid_i, .dat_busy_i,
      .txreq_issue_i, .txreq_done_i, .sr_resp_o, .sr_rdata_o, .sr_undef_o,
      .sr_trap_o, .sr_trap_el3_o, .sr_syndrome_o, .pf_range_min_o,
      .pf_range_max_o, .req_limit_o, .req_outstanding_o, .req_allow_o);
   prt_busy_partner partner_u (.mclk_i(mclk_i),
      .rsp_busy_valid_o(rsp_busy_valid_i), .rsp_busy_o(rsp_busy_i),
      .dat_busy_valid_o(dat_busy_valid_i), .dat_busy_o(dat_busy_i));

   // compare and count
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp,
      input string nm);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one system register access, answer sampled in its response cycle
   task automatic acc(input logic w, input logic [15:0] enc,
      input prt_el_t el, input logic [3:0] cf, input logic [63:0] wd);
      @(posedge mclk_i);
      sr_req_i <= 1'b1;
      sr_write_i <= w;
      sr_enc_i <= enc;
      sr_el_i <= el;
      sr_wdata_i <= wd;
      {itrap, el2_enabled_i, el2_wen_i, el3_wen_i} <= cf;
      @(posedge mclk_i);
      sr_req_i <= 1'b0;
      #1;
      chk(sr_resp_o, 1'b1, "response");
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask
   // expected {undefined, hypervisor trap, monitor trap}
   function automatic logic [2:0] fexp(input prt_el_t el, input logic w,
      input logic [3:0] c);
      if (el == PRT_EL0) return 3'b100;
      if (el == PRT_EL1 && c[2] && c[3]) return 3'b010;
      if (!w || el == PRT_EL3) return 3'b000;
      if (c[2] && !c[1]) return 3'b010;
      if (!c[0]) return 3'b001;
      return 3'b000;
   endfunction
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // clock
   initial begin
      mclk_i = 1'b0;
      forever #2 mclk_i = ~mclk_i;
   end
   // watchdog
   initial begin
      #100000;
      err_count++;
      conclude();
   end
   // test sequence
   initial begin
      {rst_n_i, sr_req_i, sr_write_i, el2_enabled_i, itrap} = 5'h0;
      {el2_wen_i, el3_wen_i, txreq_issue_i, txreq_done_i} = 4'h0;
      ce_i = 1'b1;
      sr_enc_i = 16'h0;
      sr_el_i = PRT_EL0;
      sr_wdata_i = 64'h0;
      repeat (5) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      tick(2);
      chk(req_limit_o, TQ, "reset limit");
      chk({pf_range_min_o, pf_range_max_o}, 4'h0, "reset pf");
      acc(1'b0, PRT_ENC_CTL2, PRT_EL3, 4'hf, 64'h0);
      chk(sr_rdata_o, 64'h0, "reset read");
      $display("test reset done");
      shadow = 15'h0;
      for (int i = 0; i < 128; i++) begin
         f = fexp(prt_el_t'(i[6:5]), i[4], i[3:0]);
         acc(i[4], PRT_ENC_CTL2, prt_el_t'(i[6:5]), i[3:0],
            {8'ha5, 49'h0, i[6:0]});
         chk(sr_undef_o, f[2], "undef");
         chk(sr_trap_o && !sr_trap_el3_o, f[1], "hyp trap");
         chk(sr_trap_el3_o, f[0], "mon trap");
         chk(sr_syndrome_o, (|f[1:0]) ? PRT_EC_SYSREG : 6'h0, "synd");
         if (f == 3'b000 && i[4]) shadow = {8'h0, i[6:0]};
         if (f == 3'b000 && !i[4]) chk(sr_rdata_o, shadow, "read");
      end
      $display("test access done");
      acc(1'b1, PRT_ENC_PPM, PRT_EL3, 4'h0, 64'hfedc_ba98_7654_3210);
      acc(1'b1, PRT_ENC_PPM, PRT_EL2, 4'hf, 64'h0);
      chk(sr_undef_o, 1'b1, "mgmt undef");
      acc(1'b0, PRT_ENC_PPM, PRT_EL3, 4'h0, 64'h0);
      chk(sr_rdata_o, 64'hfedc_ba98_7654_3210, "mgmt read");
      $display("test management done");
      for (int c = 0; c < 11; c++) begin
         acc(1'b1, PRT_ENC_CTL2, PRT_EL3, 4'h0, 64'(c) << 11);
         chk(sr_undef_o | sr_trap_el3_o, 1'b0, "pf write");
         tick(1);
         chk({pf_range_min_o, pf_range_max_o}, pft[c], "pf range");
      end
      $display("test prefetch done");
      acc(1'b1, PRT_ENC_CTL2, PRT_EL3, 4'h0, 64'h3);
      @(posedge mclk_i);
      txreq_issue_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      txreq_issue_i <= 1'b0;
      tick(1);
      chk(req_outstanding_o, 4, "outstanding");
      chk(req_allow_o, 1'b0, "allow at cap");
      @(posedge mclk_i);
      txreq_done_i <= 1'b1;
      txreq_issue_i <= 1'b1;
      @(posedge mclk_i);
      txreq_issue_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
      txreq_done_i <= 1'b0;
      tick(1);
      chk(req_outstanding_o, 0, "drained");
      chk(req_allow_o, 1'b1, "allow drained");
      for (int c = 3; c >= 0; c--) begin
         acc(1'b1, PRT_ENC_CTL2, PRT_EL3, 4'h0, 64'(c));
         tick(2);
         chk(req_limit_o, TQ - c * TQ / 4, "static cap");
      end
      $display("test static done");
      acc(1'b1, PRT_ENC_CTL2, PRT_EL3, 4'h0, 64'h3bc);
      for (int j = 0; j < 7; j++) begin
         if (j == 5) acc(1'b1, PRT_ENC_CTL2, PRT_EL3, 4'h0, 64'h53c);
         partner_u.burst(64, bk[j], bh[j], bc[j]);
         tick(4);
         chk(req_limit_o, bl[j], "dynamic limit");
      end
      acc(1'b1, PRT_ENC_CTL2, PRT_EL3, 4'h0, 64'h0);
      tick(2);
      chk(req_limit_o, TQ, "back to static");
      $display("test dynamic done");
      conclude();
   end
endmodule
